// ==== sfb_pkg.sv ====
// package: register map, field layout, reset values and encodings of the synthesizer control
// Contract
// R1 - frequency step is reference over two to the nineteen, nineteen-bit fraction
// R2 - carrier word is 24 bits over three byte registers, carrier is step times word
// R3 - writing upper or middle byte does not change the active carrier
// R4 - host writes upper bytes first and ends with the low byte
// R5 - with sequencer on, synthesizer starts once the oscillator is stable
// R6 - manual host waits oscillator startup or reference clock before synthesizer
// R7 - reference clock output shows no edges until the oscillator is stable
// R8 - fifth io pin carries reference or a fraction chosen by the divider select
// R9 - reference clock output on after reset, stopped only in sleep; the code also stops it for divider selects above 5
// R10 - host turns the reference clock output off when unused
// R11 - coarse calibration after reset, fine calibration on each synthesizer start
// R12 - with sequencer on, receiver or transmitter starts once the synthesizer locks
// R13 - manual host waits lock time or lock indicator before receiver or transmitter
// R14 - lock indicator goes high when the synthesizer is in locking range
// R15 - host tolerates lock indicator dropping during wide-deviation keying
// R16 - keyed modulation up to 300 kb/s inside the loop bandwidth
// R17 - continuous unshaped data is asynchronous; shaped data follows the bit clock
// R18 - packet or shaped continuous bit rate is reference over the divisor; the code raises divisors below 2 to 2
// R19 - carrier bytes read back as last written, before the low byte commits
package sfb_pkg;
   localparam int FREQUENCY_STEP_FRAC_BITS = 19;
   localparam int CARRIER_BITS = 24;
   localparam int BR_BITS = 16;
   localparam logic [6:0] ADDR_OPMODE = 7'h01;
   localparam logic [6:0] ADDR_DATAMOD = 7'h02;
   localparam logic [6:0] ADDR_BR_MSB = 7'h03;
   localparam logic [6:0] ADDR_BR_LSB = 7'h04;
   localparam logic [6:0] ADDR_FRF_MSB = 7'h07;
   localparam logic [6:0] ADDR_FRF_MID = 7'h08;
   localparam logic [6:0] ADDR_FRF_LSB = 7'h09;
   localparam logic [6:0] ADDR_IOMAP2 = 7'h26;
   localparam logic [6:0] ADDR_STATUS = 7'h27;
   localparam int OPMODE_SEQ_OFF_BIT = 7;
   localparam int OPMODE_MODE_LSB = 2;
   localparam int DATAMOD_CONT_BIT = 6;
   localparam int DATAMOD_SHAPE_LSB = 0;
   localparam int CLKSEL_LSB = 0;
   localparam logic [2:0] CLKSEL_MAX = 3'h5;
   localparam logic [2:0] CLKSEL_OFF = 3'h7;
   localparam logic [7:0] OPMODE_RST = 8'h04;
   localparam logic [7:0] DATAMOD_RST = 8'h00;
   localparam logic [7:0] IOMAP2_RST = 8'h00;
   localparam logic [15:0] BR_RST = 16'h1A0B;
   localparam logic [15:0] BR_MIN = 16'h0002;
   localparam logic [23:0] FRF_RST = 24'h000000;
   localparam logic [2:0] SPI_LAST_BIT = 3'h7;
   typedef enum logic [2:0] {
      MODE_SLEEP = 3'b000,
      MODE_STDBY = 3'b001,
      MODE_FS = 3'b010,
      MODE_TX = 3'b011,
      MODE_RX = 3'b100
   } sfb_mode_t;
   typedef enum logic [1:0] {
      SEQ_BOOT = 2'b00,
      SEQ_COARSE = 2'b01,
      SEQ_ACTIVE = 2'b10
   } sfb_seq_t;
endpackage

// ==== sfb_div_if.sv ====
// interface: request and answer of one rate divider
`timescale 1ns/1ps
`default_nettype none
interface sfb_div_if #(parameter int W = 16);
   logic [W-1:0] divisor;
   logic run;
   logic tick;
   logic level;
   modport ctrl (output divisor, output run, input tick, input level);
   modport div (input divisor, input run, output tick, output level);
endinterface
`default_nettype wire

// ==== sfb_rate_div.sv ====
// module: free divider giving a one-cycle tick and a half-duty level per period
`timescale 1ns/1ps
`default_nettype none
module sfb_rate_div #(parameter int W = 16) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // divider port
   sfb_div_if.div dv
);
   import sfb_pkg::*;
   typedef struct packed {
      logic [W-1:0] cnt;
      logic lvl;
      logic tick;
   } sfb_div_t;
   sfb_div_t s;
   sfb_div_t n;

   always_comb begin
      n = s;
      if (!dv.run) begin
         // preload so the first running cycle wraps: the first rising level carries a tick
         n.cnt = '1;
         n.lvl = 1'b0;
         n.tick = 1'b0;
      end else begin
         if (s.cnt >= dv.divisor - 1'b1) begin
            n.cnt = '0;
         end else begin
            n.cnt = s.cnt + 1'b1;
         end
         n.tick = (n.cnt == '0);
         n.lvl = (n.cnt < (dv.divisor >> 1));
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign dv.tick = s.tick;
   assign dv.level = s.lvl;
endmodule
`default_nettype wire

// ==== sfb_synth_ctrl.sv ====
// module: register port, startup sequencer, reference clock output and bit clock of the synthesizer
`timescale 1ns/1ps
`default_nettype none
module sfb_synth_ctrl (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // register port pins
   input wire logic spiSck,
   input wire logic spiMosi,
   input wire logic spiNssN,
   output logic spiMiso,
   output logic spiMisoOe,
   // oscillator and synthesizer
   input wire logic oscStableIn,
   input wire logic pllLockIn,
   output logic oscEnable,
   output logic synthEnable,
   output logic coarseCalStart,
   output logic fineCalStart,
   output logic rxEnable,
   output logic txEnable,
   output logic [sfb_pkg::CARRIER_BITS-1:0] carrierWord,
   output logic [sfb_pkg::CARRIER_BITS-sfb_pkg::FREQUENCY_STEP_FRAC_BITS-1:0] carrierIntPart,
   output logic [sfb_pkg::FREQUENCY_STEP_FRAC_BITS-1:0] carrierFracPart,
   // digital io
   output logic refClockOut,
   output logic pllLockOut,
   output logic bitClockOut,
   output logic bitClockOe,
   input wire logic serialDataIn,
   output logic txBitOut
);
   import sfb_pkg::*;
   typedef struct packed {
      logic sckS1, sckS2, sckS3, mosiS1, mosiS2, nssS1, nssS2;
      logic dataS1, dataS2, oscS1, oscS2, lockS1, lockS2;
      logic [2:0] bitCnt;
      logic inAddr;
      logic isWrite;
      logic [6:0] addr;
      logic [7:0] shIn;
      logic [7:0] shOut;
      logic [7:0] opMode;
      logic [7:0] dataMod;
      logic [15:0] brDiv;
      logic [7:0] frfMsb;
      logic [7:0] frfMid;
      logic [7:0] carrier_low_byte;
      logic [23:0] frfActive;
      logic [7:0] ioMap2;
      sfb_seq_t seq;
      logic coarseCal, fineCal, synthEn, txEn, rxEn, oscEn;
      logic refGate;
      logic txBit;
   } sfb_state_t;
   sfb_state_t s;
   sfb_state_t n;

   sfb_div_if #(.W(BR_BITS)) refIf();
   sfb_div_if #(.W(BR_BITS)) bitIf();

   sfb_mode_t mode;
   logic seqOn, wantSynth, contMode, shaped, sckRise, sckFall;
   logic [2:0] clkSel;
   logic [15:0] brEff;
   logic wrStrobe, wrLsb, wrMsb;
   logic [7:0] wrByte;

   // status word: oscillator, synthesizer, transmitter, lock, receiver
   function automatic logic [7:0] readReg(input logic [6:0] a, input sfb_state_t st);
      logic [7:0] d;
      d = 8'h00;
      if (a == ADDR_OPMODE) begin
         d = st.opMode;
      end else if (a == ADDR_DATAMOD) begin
         d = st.dataMod;
      end else if (a == ADDR_BR_MSB) begin
         d = st.brDiv[15:8];
      end else if (a == ADDR_BR_LSB) begin
         d = st.brDiv[7:0];
      end else if (a == ADDR_FRF_MSB) begin
         d = st.frfMsb; // see R19
      end else if (a == ADDR_FRF_MID) begin
         d = st.frfMid; // see R19
      end else if (a == ADDR_FRF_LSB) begin
         d = st.carrier_low_byte;
      end else if (a == ADDR_IOMAP2) begin
         d = st.ioMap2;
      end else if (a == ADDR_STATUS) begin
         d = {st.oscS2, st.synthEn, st.txEn, st.lockS2, st.rxEn, 3'h0};
      end
      return d;
   endfunction

   assign mode = sfb_mode_t'(s.opMode[OPMODE_MODE_LSB +: 3]);
   assign seqOn = !s.opMode[OPMODE_SEQ_OFF_BIT];
   assign wantSynth = (mode == MODE_FS) || (mode == MODE_TX) || (mode == MODE_RX);
   assign contMode = s.dataMod[DATAMOD_CONT_BIT];
   assign shaped = (s.dataMod[DATAMOD_SHAPE_LSB +: 2] != 2'h0);
   assign clkSel = s.ioMap2[CLKSEL_LSB +: 3];
   // a zero or one divisor would stall the bit clock, so clamp it
   assign brEff = (s.brDiv < BR_MIN) ? BR_MIN : s.brDiv; // see R18
   assign sckRise = s.sckS2 && !s.sckS3;
   assign sckFall = !s.sckS2 && s.sckS3;

   always_comb begin
      n = s;
      wrStrobe = 1'b0;
      wrByte = {s.shIn[6:0], s.mosiS2};
      n.sckS1 = spiSck;
      n.sckS2 = s.sckS1;
      n.sckS3 = s.sckS2;
      n.mosiS1 = spiMosi;
      n.mosiS2 = s.mosiS1;
      n.nssS1 = spiNssN;
      n.nssS2 = s.nssS1;
      n.dataS1 = serialDataIn;
      n.dataS2 = s.dataS1;
      n.oscS1 = oscStableIn;
      n.oscS2 = s.oscS1;
      n.lockS1 = pllLockIn;
      n.lockS2 = s.lockS1;
      // register port: address byte with write flag, then bytes at rising addresses
      if (s.nssS2) begin
         n.bitCnt = 3'h0;
         n.inAddr = 1'b1;
         n.shOut = 8'h00;
      end else if (sckRise) begin
         n.shIn = wrByte;
         n.bitCnt = s.bitCnt + 3'h1;
         if (s.bitCnt == SPI_LAST_BIT) begin
            if (s.inAddr) begin
               n.inAddr = 1'b0;
               n.isWrite = wrByte[7];
               n.addr = wrByte[6:0];
               n.shOut = readReg(wrByte[6:0], s);
            end else begin
               wrStrobe = s.isWrite;
               n.addr = s.addr + 7'h01;
               n.shOut = readReg(s.addr + 7'h01, s);
            end
         end
      end else if (sckFall && (s.bitCnt != 3'h0) && !s.inAddr) begin
         n.shOut = {s.shOut[6:0], 1'b0};
      end
      if (wrStrobe) begin
         if (s.addr == ADDR_OPMODE) begin
            n.opMode = wrByte;
         end else if (s.addr == ADDR_DATAMOD) begin
            n.dataMod = wrByte;
         end else if (s.addr == ADDR_BR_MSB) begin
            n.brDiv[15:8] = wrByte;
         end else if (s.addr == ADDR_BR_LSB) begin
            n.brDiv[7:0] = wrByte;
         end else if (s.addr == ADDR_FRF_MSB) begin
            n.frfMsb = wrByte; // see R3
         end else if (s.addr == ADDR_FRF_MID) begin
            n.frfMid = wrByte; // see R3
         end else if (s.addr == ADDR_FRF_LSB) begin
            n.carrier_low_byte = wrByte;
            n.frfActive = {s.frfMsb, s.frfMid, wrByte}; // see R2, R3
         end else if (s.addr == ADDR_IOMAP2) begin
            n.ioMap2 = wrByte;
         end
      end
      // startup sequencer
      n.coarseCal = 1'b0;
      n.oscEn = (mode != MODE_SLEEP);
      case (s.seq)
         SEQ_BOOT: begin
            n.seq = SEQ_COARSE;
         end
         SEQ_COARSE: begin
            n.coarseCal = 1'b1; // see R11
            n.seq = SEQ_ACTIVE;
         end
         default: begin
            n.seq = SEQ_ACTIVE;
         end
      endcase
      if (s.seq != SEQ_ACTIVE) begin
         n.synthEn = 1'b0;
         n.txEn = 1'b0;
         n.rxEn = 1'b0;
      end else if (seqOn) begin
         n.synthEn = wantSynth && s.oscS2; // see R5
         // once running, a lock drop during wide keying does not stop the path
         n.txEn = (mode == MODE_TX) && s.synthEn && (s.lockS2 || s.txEn); // see R12
         n.rxEn = (mode == MODE_RX) && s.synthEn && (s.lockS2 || s.rxEn); // see R12
      end else begin
         n.synthEn = wantSynth;
         n.txEn = (mode == MODE_TX);
         n.rxEn = (mode == MODE_RX);
      end
      n.fineCal = n.synthEn && !s.synthEn; // see R11
      // reference clock gate follows the stable oscillator, off in sleep
      n.refGate = s.oscS2 && (mode != MODE_SLEEP) && (clkSel <= CLKSEL_MAX); // see R7, R9
      // unshaped continuous data passes straight; otherwise taken on the bit clock edge
      if (contMode && !shaped) begin
         n.txBit = s.dataS2; // see R17
      end else if (bitIf.tick) begin
         n.txBit = s.dataS2; // see R17
      end
   end

   assign wrLsb = wrStrobe && (s.addr == ADDR_FRF_LSB);
   assign wrMsb = wrStrobe && (s.addr == ADDR_FRF_MSB);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s <= '0;
         s.sckS1 <= 1'b0;
         s.nssS1 <= 1'b1;
         s.nssS2 <= 1'b1;
         s.inAddr <= 1'b1;
         s.opMode <= OPMODE_RST;
         s.dataMod <= DATAMOD_RST;
         s.brDiv <= BR_RST;
         s.frfMsb <= FRF_RST[23:16];
         s.frfMid <= FRF_RST[15:8];
         s.carrier_low_byte <= FRF_RST[7:0];
         s.frfActive <= FRF_RST;
         s.ioMap2 <= IOMAP2_RST; // see R9
         s.seq <= SEQ_BOOT;
      end else begin
         s <= n;
      end
   end

   assign refIf.run = s.refGate;
   assign refIf.divisor = 16'h0001 << clkSel; // see R8
   assign bitIf.run = (!contMode || shaped) && (s.txEn || s.rxEn); // see R18
   assign bitIf.divisor = brEff; // see R18

   sfb_rate_div #(.W(BR_BITS)) uRefDiv (.clk(ref_clk), .reset(reset), .dv(refIf.div));
   sfb_rate_div #(.W(BR_BITS)) uBitDiv (.clk(ref_clk), .reset(reset), .dv(bitIf.div));

   assign spiMiso = s.shOut[7];
   assign spiMisoOe = !s.nssS2;
   assign oscEnable = s.oscEn;
   assign synthEnable = s.synthEn;
   assign coarseCalStart = s.coarseCal;
   assign fineCalStart = s.fineCal;
   assign rxEnable = s.rxEn;
   assign txEnable = s.txEn;
   assign carrierWord = s.frfActive; // see R2
   // integer and nineteen-bit fraction feed the sigma-delta divider
   assign carrierIntPart = s.frfActive[CARRIER_BITS-1:FREQUENCY_STEP_FRAC_BITS]; // see R1
   assign carrierFracPart = s.frfActive[FREQUENCY_STEP_FRAC_BITS-1:0]; // see R1
   // full-rate select passes the clock itself; the gate flop changes while the clock
   // is high, so a short first pulse is possible on enable
   assign refClockOut = s.refGate && ((clkSel == 3'h0) ? ref_clk : refIf.level); // see R7, R8
   assign pllLockOut = s.lockS2; // see R14
   assign bitClockOut = bitIf.level; // see R17
   assign bitClockOe = contMode && shaped; // see R17
   assign txBitOut = s.txBit;

   // assertion helpers: gap between bit ticks under a steady divisor
   logic [15:0] tickGap;
   logic gapOk;
   logic [15:0] brEffQ;
   always_ff @(posedge ref_clk) begin
      brEffQ <= brEff;
      if (reset || !bitIf.run || (brEff != brEffQ)) begin
         tickGap <= 16'h0000;
         gapOk <= 1'b0;
      end else if (bitIf.tick) begin
         tickGap <= 16'h0000;
         gapOk <= 1'b1;
      end else begin
         tickGap <= tickGap + 16'h0001;
      end
   end

   AST_FRF_HOLD: assert property (@(posedge ref_clk) disable iff (reset) // see R3
      !wrLsb |=> $stable(carrierWord)) else $error("carrier changed without low byte write");
   AST_FRF_COMMIT: assert property (@(posedge ref_clk) disable iff (reset) // see R2
      wrLsb |=> (carrierWord == {s.frfMsb, s.frfMid, s.carrier_low_byte}))
      else $error("carrier word not committed from staged bytes");
   AST_FRF_READBACK: assert property (@(posedge ref_clk) disable iff (reset) // see R19
      wrMsb |=> (s.frfMsb == $past(wrByte)) && $stable(carrierWord))
      else $error("upper carrier byte not held for readback");
   AST_SYNTH_AUTO: assert property (@(posedge ref_clk) disable iff (reset) // see R5
      (s.seq == SEQ_ACTIVE && seqOn && wantSynth && s.oscS2) |=> synthEnable)
      else $error("synthesizer not started on stable oscillator");
   AST_REF_GATED: assert property (@(posedge ref_clk) disable iff (reset) // see R7
      (!s.oscS2)[*2] |-> !s.refGate) else $error("reference clock enabled before oscillator stable");
   AST_REF_SLEEP: assert property (@(posedge ref_clk) disable iff (reset) // see R9
      (mode == MODE_SLEEP)[*2] |-> !refIf.run) else $error("reference clock running in sleep");
   AST_COARSE_CAL: assert property (@(posedge ref_clk) disable iff (reset) // see R11
      $fell(reset) |-> ##[1:3] coarseCalStart) else $error("no coarse calibration after reset");
   AST_FINE_CAL: assert property (@(posedge ref_clk) disable iff (reset) // see R11
      $rose(synthEnable) |-> fineCalStart ##1 !fineCalStart)
      else $error("fine calibration pulse missing on synthesizer start");
   AST_TX_AFTER_LOCK: assert property (@(posedge ref_clk) disable iff (reset) // see R12
      (seqOn && mode == MODE_TX && s.synthEn && s.lockS2) |=> txEnable)
      else $error("transmitter not started after lock");
   AST_BIT_RATE: assert property (@(posedge ref_clk) disable iff (reset) // see R18
      (bitIf.tick && gapOk && bitIf.run) |-> (tickGap == brEff - 16'h0001))
      else $error("bit period differs from divisor");
endmodule
`default_nettype wire

// ==== sfb_host_data.sv ====
// partner model: host data source on the serial data pin
`timescale 1ns/1ps
`default_nettype none
module sfb_host_data (
   // clock
   input wire logic clk,
   // bit clock pin
   input wire logic bitClk,
   input wire logic bitClkOe,
   // data pin
   output logic data
);
   logic [7:0] pat;
   logic lastClk;
   int cnt;
   initial begin
      data = 1'b0;
      pat = 8'hB4;
      lastClk = 1'b0;
      cnt = 0;
   end
   // with the bit clock driven, new bit just after it falls, so it has settled long before the next rise; otherwise data toggles every 13 cycles
   always @(negedge clk) begin
      lastClk <= bitClk;
      cnt <= cnt + 1;
      if (bitClkOe) begin
         if (lastClk && !bitClk) begin
            data <= pat[7];
            pat <= {pat[6:0], pat[7]};
         end
      end else if (cnt % 13 == 0) begin
         data <= ~data;
      end
   end
endmodule
`default_nettype wire

// ==== tb_synth_freq_and_symbol_rate_divisor_ctrl.sv ====
// testbench: register port, carrier commit, reference clock output, sequencer and bit clock
`timescale 1ns/1ps
`default_nettype none
module tb_synth_freq_and_symbol_rate_divisor_ctrl;
   import sfb_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic spiSck = 1'b0;
   logic spiMosi = 1'b0;
   logic spiNssN = 1'b1;
   logic oscStableIn = 1'b0;
   logic pllLockIn = 1'b0;
   logic spiMiso, spiMisoOe, oscEnable, synthEnable, coarseCalStart, fineCalStart;
   logic rxEnable, txEnable, refClockOut, pllLockOut, bitClockOut, bitClockOe;
   logic serialDataIn, txBitOut, bcLast;
   logic [CARRIER_BITS-1:0] carrierWord;
   logic [CARRIER_BITS-FREQUENCY_STEP_FRAC_BITS-1:0] carrierIntPart;
   logic [FREQUENCY_STEP_FRAC_BITS-1:0] carrierFracPart;
   logic [7:0] rdv;
   int errCount = 0;
   int checkCount = 0;
   int cyc = 0, lastRise = 0, bcPer = 0, edgeCnt = 0, coarseCnt = 0, fineCnt = 0;
   event bcRise;
   logic [6:0] ra [0:9] = '{ADDR_OPMODE, ADDR_DATAMOD, ADDR_BR_MSB, ADDR_BR_LSB, ADDR_FRF_MSB,
      ADDR_FRF_MID, ADDR_FRF_LSB, ADDR_IOMAP2, ADDR_STATUS, 7'h10};
   logic [7:0] rv [0:9] = '{OPMODE_RST, DATAMOD_RST, BR_RST[15:8], BR_RST[7:0], FRF_RST[23:16],
      FRF_RST[15:8], FRF_RST[7:0], IOMAP2_RST, 8'h00, 8'h00};

   always #25 ref_clk = ~ref_clk;

   sfb_synth_ctrl uut (.ref_clk, .reset, .spiSck, .spiMosi, .spiNssN, .spiMiso, .spiMisoOe,
      .oscStableIn, .pllLockIn, .oscEnable, .synthEnable, .coarseCalStart, .fineCalStart,
      .rxEnable, .txEnable, .carrierWord, .carrierIntPart, .carrierFracPart, .refClockOut,
      .pllLockOut, .bitClockOut, .bitClockOe, .serialDataIn, .txBitOut);
   sfb_host_data host (.clk(ref_clk), .bitClk(bitClockOut), .bitClkOe(bitClockOe),
      .data(serialDataIn));

   initial bcLast = 1'b0;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      bcLast <= bitClockOut;
      if (!reset && coarseCalStart === 1'b1) coarseCnt <= coarseCnt + 1;
      if (!reset && fineCalStart === 1'b1) fineCnt <= fineCnt + 1;
      if (bitClockOut === 1'b1 && bcLast === 1'b0) begin
         bcPer <= cyc - lastRise;
         lastRise <= cyc;
         -> bcRise;
      end
   end
   always @(posedge refClockOut) edgeCnt++;

   task chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checkCount++;
      if (g !== e) begin
         errCount++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task chk_rng(input string n, input int lo, input int hi, input int g);
      checkCount++;
      if (g < lo || g > hi) begin
         errCount++;
         $display("Error %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   // mode 0 byte, half period of 4 cycles keeps the 400 ns minimum sck period
   task sbyte(input logic [7:0] o, output logic [7:0] i);
      for (int b = 7; b >= 0; b--) begin
         spiMosi = o[b];
         repeat (4) @(negedge ref_clk);
         i[b] = spiMiso;
         spiSck = 1'b1;
         repeat (4) @(negedge ref_clk);
         spiSck = 1'b0;
      end
   endtask
   task sel(input logic on);
      if (!on) repeat (4) @(negedge ref_clk);
      spiNssN = !on;
      repeat (4) @(negedge ref_clk);
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] x;
      sel(1'b1);
      sbyte({1'b1, a}, x);
      sbyte(d, x);
      sel(1'b0);
   endtask
   task wr3(input logic [6:0] a, input logic [23:0] d);
      logic [7:0] x;
      sel(1'b1);
      sbyte({1'b1, a}, x);
      for (int k = 2; k >= 0; k--) sbyte(d[8*k +: 8], x);
      sel(1'b0);
   endtask
   task rd(input logic [6:0] a, output logic [7:0] d);
      logic [7:0] x;
      sel(1'b1);
      chk("spiMisoOe", 1, spiMisoOe);
      sbyte({1'b0, a}, x);
      sbyte(8'h00, d);
      sel(1'b0);
   endtask
   task edges(input int lo, input int hi);
      edgeCnt = 0;
      repeat (64) @(negedge ref_clk);
      chk_rng("refClockOut edges", lo, hi, edgeCnt);
   endtask
   task results;
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // the whole sequence needs well under 20000 cycles
   initial begin
      #2000000;
      errCount++;
      results();
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("coarseCalStart pulses", 1, coarseCnt);
      chk("spiMisoOe", 0, spiMisoOe);
      for (int k = 0; k < 10; k++) begin
         rd(ra[k], rdv);
         chk("reset value", rv[k], rdv & ((ra[k] == ADDR_STATUS) ? 8'hF8 : 8'hFF));
      end
      wr(ADDR_STATUS, 8'hFF);
      wr(7'h10, 8'h5A);
      rd(ADDR_STATUS, rdv);
      chk("status", 8'h00, rdv & 8'hF8);
      rd(7'h10, rdv);
      chk("unmapped", 8'h00, rdv);
      edges(0, 0);
      $display("test registers done");
      oscStableIn = 1'b1;
      repeat (8) @(negedge ref_clk);
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_IOMAP2, 8'(s));
         edges(s > 5 ? 0 : (64 >> s) - 1, s > 5 ? 0 : (64 >> s) + 1);
      end
      wr(ADDR_IOMAP2, 8'h00);
      wr(ADDR_OPMODE, 8'h00);
      chk("oscEnable", 0, oscEnable);
      edges(0, 0);
      wr(ADDR_OPMODE, OPMODE_RST);
      chk("oscEnable", 1, oscEnable);
      edges(63, 65);
      $display("test reference clock done");
      wr(ADDR_FRF_MSB, 8'h12);
      wr(ADDR_FRF_MID, 8'h34);
      chk("carrierWord", FRF_RST, carrierWord);
      rd(ADDR_FRF_MSB, rdv);
      chk("carrier high byte", 8'h12, rdv);
      rd(ADDR_FRF_MID, rdv);
      chk("carrier middle byte", 8'h34, rdv);
      wr(ADDR_FRF_LSB, 8'h56);
      chk("carrierWord", 24'h123456, carrierWord);
      wr3(ADDR_FRF_MSB, 24'hABCDEF);
      chk("carrierWord", 24'hABCDEF, carrierWord);
      chk("carrierIntPart", 24'hABCDEF >> FREQUENCY_STEP_FRAC_BITS, carrierIntPart);
      chk("carrierFracPart", 24'hABCDEF & 24'h07FFFF, carrierFracPart);
      $display("test carrier done");
      wr(ADDR_DATAMOD, 8'h41);
      chk("bitClockOe", 1, bitClockOe);
      wr(ADDR_BR_MSB, 8'h00);
      wr(ADDR_BR_LSB, 8'h10);
      wr(ADDR_OPMODE, 8'h0C);
      chk("synthEnable", 1, synthEnable);
      chk("fineCalStart pulses", 1, fineCnt);
      chk("txEnable", 0, txEnable);
      pllLockIn = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk("txEnable", 1, txEnable);
      chk("pllLockOut", 1, pllLockOut);
      rd(ADDR_STATUS, rdv);
      chk("status", 8'hF0, rdv & 8'hF8);
      for (int k = 0; k < 4; k++) begin
         @(bcRise);
         repeat (6) @(negedge ref_clk);
         chk("txBitOut", serialDataIn, txBitOut);
      end
      chk_rng("bit clock period", 16, 16, bcPer);
      wr(ADDR_BR_LSB, 8'h01);
      repeat (20) @(negedge ref_clk);
      chk_rng("bit clock period", 2, 2, bcPer);
      pllLockIn = 1'b0;
      repeat (8) @(negedge ref_clk);
      chk("pllLockOut", 0, pllLockOut);
      chk("txEnable", 1, txEnable);
      wr(ADDR_OPMODE, OPMODE_RST);
      chk("synthEnable", 0, synthEnable);
      chk("txEnable", 0, txEnable);
      $display("test sequencer done");
      edges(63, 65);
      wr(ADDR_OPMODE, 8'h88);
      chk("synthEnable", 1, synthEnable);
      chk("fineCalStart pulses", 2, fineCnt);
      pllLockIn = 1'b1;
      for (int k = 0; k < 20 && pllLockOut !== 1'b1; k++) @(negedge ref_clk);
      wr(ADDR_OPMODE, 8'h90);
      chk("rxEnable", 1, rxEnable);
      chk("txEnable", 0, txEnable);
      wr(ADDR_DATAMOD, 8'h40);
      chk("bitClockOe", 0, bitClockOe);
      for (int k = 0; k < 2; k++) begin
         @(serialDataIn);
         repeat (4) @(negedge ref_clk);
         chk("txBitOut", serialDataIn, txBitOut);
      end
      wr(ADDR_IOMAP2, {5'h00, CLKSEL_OFF});
      edges(0, 0);
      $display("test manual startup done");
      results();
   end
endmodule
`default_nettype wire
